/* include/port_mux_pkg.sv */
// constants for the port a / port b alternate-function multiplexer
// assumes a 32-bit apb master and 8-bit ports a and b
package port_mux_pkg;
	localparam int unsigned PORT_WIDTH = 8;
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 32;
	localparam int unsigned ANALOG_COUNT = 5;
	// register byte offsets
	localparam logic [7:0] OFS_PA_AF_ENABLE    = 8'h00;
	localparam logic [7:0] OFS_PB_AF_ENABLE    = 8'h04;
	localparam logic [7:0] OFS_PB_FSEL_FIRST   = 8'h08;
	localparam logic [7:0] OFS_PB_FSEL_SECOND  = 8'h0C;
	localparam logic [7:0] OFS_PA_DIRECTION    = 8'h10;
	localparam logic [7:0] OFS_PB_DIRECTION    = 8'h14;
	localparam logic [7:0] OFS_PA_OUT_DATA     = 8'h18;
	localparam logic [7:0] OFS_PB_OUT_DATA     = 8'h1C;
	localparam logic [7:0] OFS_PIN_LEVELS      = 8'h20;
	// reset values
	localparam logic [7:0] RST_AF_ENABLE  = 8'h00;
	localparam logic [7:0] RST_FSEL       = 8'h00;
	localparam logic [7:0] RST_DIRECTION  = 8'h00;
	localparam logic [7:0] RST_OUT_DATA   = 8'h00;
	// port a pin positions
	localparam int unsigned PA_TIMER0_IO   = 0;
	localparam int unsigned PA_TIMER0_TRUE = 1;
	localparam int unsigned PA_SER_DE      = 2;
	localparam int unsigned PA_SER_CTS     = 3;
	localparam int unsigned PA_SER_RX      = 4;
	localparam int unsigned PA_SER_TX      = 5;
	localparam int unsigned PA_TIMER1_IO   = 6;
	localparam int unsigned PA_TIMER1_TRUE = 7;
	// port b pin positions
	localparam int unsigned PB_CLOCK_IN = 3;
	localparam int unsigned PB_ANALOG7  = 4;
	localparam int unsigned PB_VREF     = 5;
endpackage

/* core/port_ab_alt_function_mux.sv */
// alternate-function routing for port a and port b pads, with apb registers
// assumes pads are external (three-flop synchronised) and peripherals share i_clk
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module port_ab_alt_function_mux #(
	parameter bit BUILD_28PIN = 1'b1
) (
	input  wire logic                                i_clk,
	input  wire logic                                i_resetn,
	input  wire logic                                i_psel,
	input  wire logic                                i_penable,
	input  wire logic                                i_pwrite,
	input  wire logic [port_mux_pkg::ADDR_WIDTH-1:0] i_paddr,
	input  wire logic [port_mux_pkg::DATA_WIDTH-1:0] i_pwdata,
	output logic      [port_mux_pkg::DATA_WIDTH-1:0] o_prdata,
	output logic                                     o_pready,
	output logic                                     o_pslverr,
	input  wire logic [port_mux_pkg::PORT_WIDTH-1:0] i_pa_pad,
	input  wire logic [port_mux_pkg::PORT_WIDTH-1:0] i_pb_pad,
	output logic      [port_mux_pkg::PORT_WIDTH-1:0] o_pa_out,
	output logic      [port_mux_pkg::PORT_WIDTH-1:0] o_pa_oe,
	output logic      [port_mux_pkg::PORT_WIDTH-1:0] o_pb_out,
	output logic      [port_mux_pkg::PORT_WIDTH-1:0] o_pb_oe,
	input  wire logic                                i_crystal_enable,
	input  wire logic                                i_timer0_true_out,
	input  wire logic                                i_timer0_pin_out,
	input  wire logic                                i_timer0_drives_pin,
	input  wire logic                                i_timer1_true_out,
	input  wire logic                                i_timer1_pin_out,
	input  wire logic                                i_timer1_drives_pin,
	input  wire logic                                i_serial0_driver_enable,
	input  wire logic                                i_serial0_transmit,
	output logic                                     o_timer0_pin_in,
	output logic                                     o_timer1_pin_in,
	output logic                                     o_serial0_clear_to_send,
	output logic                                     o_serial0_receive,
	output logic                                     o_external_clock_input,
	output logic      [port_mux_pkg::ANALOG_COUNT-1:0] o_analog_connect,
	output logic                                     o_vref_connect
);
	import port_mux_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pad synchronisers: change accepted once stages two and three agree
	logic [15:0] sync1_q, sync2_q, sync3_q, pin_q, pin_d;

	always_comb begin
		pin_d = (sync2_q == sync3_q) ? sync3_q : pin_q;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			sync1_q <= 16'h0000;
			sync2_q <= 16'h0000;
			sync3_q <= 16'h0000;
			pin_q   <= 16'h0000;
		end else begin
			sync1_q <= {i_pb_pad, i_pa_pad};
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			pin_q   <= pin_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb slave: ready in the first access cycle, registers written there
	logic [7:0]  pa_af_q, pb_af_q, fsel1_q, fsel2_q, pa_dir_q, pb_dir_q, pa_dat_q, pb_dat_q;
	logic [7:0]  pa_af_d, pb_af_d, fsel1_d, fsel2_d, pa_dir_d, pb_dir_d, pa_dat_d, pb_dat_d;
	logic [31:0] prdata_d;
	logic        pready_d, pslverr_d, wr_en, hit;

	always_comb begin
		wr_en    = i_psel && i_penable && o_pready && i_pwrite;
		hit      = 1'b1;
		prdata_d = 32'h00000000;
		case (i_paddr)
			OFS_PA_AF_ENABLE:   prdata_d[7:0] = pa_af_q;
			OFS_PB_AF_ENABLE:   prdata_d[7:0] = pb_af_q;
			OFS_PB_FSEL_FIRST:  prdata_d[7:0] = fsel1_q;
			OFS_PB_FSEL_SECOND: prdata_d[7:0] = fsel2_q;
			OFS_PA_DIRECTION:   prdata_d[7:0] = pa_dir_q;
			OFS_PB_DIRECTION:   prdata_d[7:0] = pb_dir_q;
			OFS_PA_OUT_DATA:    prdata_d[7:0] = pa_dat_q;
			OFS_PB_OUT_DATA:    prdata_d[7:0] = pb_dat_q;
			OFS_PIN_LEVELS:     prdata_d[15:0] = pin_q;
			default:            hit = 1'b0;
		endcase
		pready_d  = i_psel && !i_penable;
		pslverr_d = i_psel && !i_penable && !hit;
		if (!(i_psel && !i_penable)) begin
			prdata_d = o_prdata;
		end
		pa_af_d  = (wr_en && i_paddr == OFS_PA_AF_ENABLE)   ? i_pwdata[7:0] : pa_af_q;
		pb_af_d  = (wr_en && i_paddr == OFS_PB_AF_ENABLE)   ? i_pwdata[7:0] : pb_af_q;
		fsel1_d  = (wr_en && i_paddr == OFS_PB_FSEL_FIRST)  ? i_pwdata[7:0] : fsel1_q;
		fsel2_d  = (wr_en && i_paddr == OFS_PB_FSEL_SECOND) ? i_pwdata[7:0] : fsel2_q;
		pa_dir_d = (wr_en && i_paddr == OFS_PA_DIRECTION)   ? i_pwdata[7:0] : pa_dir_q;
		pb_dir_d = (wr_en && i_paddr == OFS_PB_DIRECTION)   ? i_pwdata[7:0] : pb_dir_q;
		pa_dat_d = (wr_en && i_paddr == OFS_PA_OUT_DATA)    ? i_pwdata[7:0] : pa_dat_q;
		pb_dat_d = (wr_en && i_paddr == OFS_PB_OUT_DATA)    ? i_pwdata[7:0] : pb_dat_q;
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			pa_af_q   <= RST_AF_ENABLE;
			pb_af_q   <= RST_AF_ENABLE;
			fsel1_q   <= RST_FSEL;
			fsel2_q   <= RST_FSEL;
			pa_dir_q  <= RST_DIRECTION;
			pb_dir_q  <= RST_DIRECTION;
			pa_dat_q  <= RST_OUT_DATA;
			pb_dat_q  <= RST_OUT_DATA;
			o_prdata  <= 32'h00000000;
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			pa_af_q   <= pa_af_d;
			pb_af_q   <= pb_af_d;
			fsel1_q   <= fsel1_d;
			fsel2_q   <= fsel2_d;
			pa_dir_q  <= pa_dir_d;
			pb_dir_q  <= pb_dir_d;
			pa_dat_q  <= pa_dat_d;
			pb_dat_q  <= pb_dat_d;
			o_prdata  <= prdata_d;
			o_pready  <= pready_d;
			o_pslverr <= pslverr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pin routing; registered so every pad and peripheral output is a flop
	// select changes apply immediately, so enabling last avoids glitch paths
	logic [7:0] pa_out_d, pa_oe_d, pb_out_d, pb_oe_d;
	logic [4:0] analog_d;
	logic       t0_in_d, t1_in_d, cts_d, rx_d, clk_in_d, vref_d;
	logic [7:0] pa_in, pb_in;

	always_comb begin
		pa_in    = pin_q[7:0];
		pb_in    = pin_q[15:8];
		pa_out_d = pa_dat_q;
		pa_oe_d  = pa_dir_q;
		pb_out_d = pb_dat_q;
		pb_oe_d  = pb_dir_q;
		// every alternate-function pin is made an input; peripherals then take the direction of pa0, pa1, pa2, pa5, pa6 and pa7
		for (int i = 0; i < 8; i++) begin
			if (pa_af_q[i]) begin
				pa_oe_d[i]  = 1'b0;
				pa_out_d[i] = 1'b0;
			end
			if (pb_af_q[i]) begin
				pb_oe_d[i]  = 1'b0;
				pb_out_d[i] = 1'b0;
			end
		end
		if (pa_af_q[PA_TIMER0_IO]) begin
			pa_oe_d[PA_TIMER0_IO]  = i_timer0_drives_pin;
			pa_out_d[PA_TIMER0_IO] = i_timer0_pin_out;
		end
		if (pa_af_q[PA_TIMER0_TRUE]) begin
			pa_oe_d[PA_TIMER0_TRUE]  = 1'b1;
			pa_out_d[PA_TIMER0_TRUE] = i_timer0_true_out;
		end
		if (pa_af_q[PA_SER_DE]) begin
			pa_oe_d[PA_SER_DE]  = 1'b1;
			pa_out_d[PA_SER_DE] = i_serial0_driver_enable;
		end
		if (pa_af_q[PA_SER_TX]) begin
			pa_oe_d[PA_SER_TX]  = 1'b1;
			pa_out_d[PA_SER_TX] = i_serial0_transmit;
		end
		if (pa_af_q[PA_TIMER1_IO]) begin
			pa_oe_d[PA_TIMER1_IO]  = i_timer1_drives_pin;
			pa_out_d[PA_TIMER1_IO] = i_timer1_pin_out;
		end
		if (pa_af_q[PA_TIMER1_TRUE]) begin
			pa_oe_d[PA_TIMER1_TRUE]  = 1'b1;
			pa_out_d[PA_TIMER1_TRUE] = i_timer1_true_out;
		end
		// oscillator owns pins 0 and 1; the pads are released to it
		if (i_crystal_enable) begin
			pa_oe_d[1:0]  = 2'h0;
			pa_out_d[1:0] = 2'h0;
		end
		t0_in_d = pa_af_q[PA_TIMER0_IO] && !i_timer0_drives_pin && !i_crystal_enable
			&& pa_in[PA_TIMER0_IO];
		t1_in_d = pa_af_q[PA_TIMER1_IO] && !i_timer1_drives_pin && pa_in[PA_TIMER1_IO];
		// idle high when not routed, so a floating uart sees no start bit
		cts_d   = pa_af_q[PA_SER_CTS] ? pa_in[PA_SER_CTS] : 1'b1;
		rx_d    = pa_af_q[PA_SER_RX] ? pa_in[PA_SER_RX] : 1'b1;
		// second select register deliberately absent from this decode
		analog_d = pb_af_q[4:0] & fsel1_q[4:0];
		clk_in_d = pb_af_q[PB_CLOCK_IN] && !fsel1_q[PB_CLOCK_IN] && pb_in[PB_CLOCK_IN];
		vref_d   = BUILD_28PIN && pb_af_q[PB_VREF] && fsel1_q[PB_VREF];
	end

	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_pa_out                <= 8'h00;
			o_pa_oe                 <= 8'h00;
			o_pb_out                <= 8'h00;
			o_pb_oe                 <= 8'h00;
			o_timer0_pin_in         <= 1'b0;
			o_timer1_pin_in         <= 1'b0;
			o_serial0_clear_to_send <= 1'b1;
			o_serial0_receive       <= 1'b1;
			o_external_clock_input  <= 1'b0;
			o_analog_connect        <= 5'h00;
			o_vref_connect          <= 1'b0;
		end else begin
			o_pa_out                <= pa_out_d;
			o_pa_oe                 <= pa_oe_d;
			o_pb_out                <= pb_out_d;
			o_pb_oe                 <= pb_oe_d;
			o_timer0_pin_in         <= t0_in_d;
			o_timer1_pin_in         <= t1_in_d;
			o_serial0_clear_to_send <= cts_d;
			o_serial0_receive       <= rx_d;
			o_external_clock_input  <= clk_in_d;
			o_analog_connect        <= analog_d;
			o_vref_connect          <= vref_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	property p_pa1_true;
		pa_af_q[1] && !i_crystal_enable |=> o_pa_oe[1] && o_pa_out[1] == $past(i_timer0_true_out);
	endproperty
	a_pa1_true: assert property (p_pa1_true) else $error("pa1 not timer0 true out");

	property p_pa0_mode;
		pa_af_q[0] && !i_crystal_enable |=> o_pa_oe[0] == $past(i_timer0_drives_pin);
	endproperty
	a_pa0_mode: assert property (p_pa0_mode) else $error("pa0 direction not timer mode");

	property p_pa2_de;
		pa_af_q[2] |=> o_pa_oe[2] && o_pa_out[2] == $past(i_serial0_driver_enable);
	endproperty
	a_pa2_de: assert property (p_pa2_de) else $error("pa2 not driver enable");

	property p_pa5_tx;
		pa_af_q[5] |=> o_pa_oe[5] && o_pa_out[5] == $past(i_serial0_transmit);
	endproperty
	a_pa5_tx: assert property (p_pa5_tx) else $error("pa5 not transmit");

	property p_pa7_true;
		pa_af_q[7] |=> o_pa_oe[7] && o_pa_out[7] == $past(i_timer1_true_out);
	endproperty
	a_pa7_true: assert property (p_pa7_true) else $error("pa7 not timer1 true out");

	property p_fsel2_unused;
		$changed(fsel2_q) && $stable(fsel1_q) && $stable(pb_af_q) |=> $stable(o_analog_connect);
	endproperty
	a_fsel2_unused: assert property (p_fsel2_unused) else $error("second select moved routing");

	property p_analog;
		##1 o_analog_connect == $past(pb_af_q[4:0] & fsel1_q[4:0]);
	endproperty
	a_analog: assert property (p_analog) else $error("analog routing wrong");

	property p_vref;
		o_vref_connect |-> BUILD_28PIN && $past(pb_af_q[5] && fsel1_q[5]);
	endproperty
	a_vref: assert property (p_vref) else $error("vref routed without select");

	property p_pb_af_oe;
		pb_af_q != 8'h00 |=> (o_pb_oe & $past(pb_af_q)) == 8'h00;
	endproperty
	a_pb_af_oe: assert property (p_pb_af_oe) else $error("pb af pin driven by port");

	property p_xtal;
		i_crystal_enable |=> o_pa_oe[1:0] == 2'h0 && !o_timer0_pin_in;
	endproperty
	a_xtal: assert property (p_xtal) else $error("crystal pins still driven");

	property p_fsel1_write;
		wr_en && i_paddr == OFS_PB_FSEL_FIRST |=> fsel1_q == $past(i_pwdata[7:0]) && o_pready == 1'b0;
	endproperty
	a_fsel1_write: assert property (p_fsel1_write) else $error("select write lost");
endmodule
`default_nettype wire

/* verification/peripheral_side_model.sv */
// timer and serial unit outputs facing the pin mux
// assumes the bench picks each signal through i_mode; outputs land one edge later
`timescale 1ns/10ps
`default_nettype none
module peripheral_side_model (
	input  wire logic       i_clk,
	input  wire logic       i_resetn,
	input  wire logic [7:0] i_mode,
	output logic            o_timer0_true_out,
	output logic            o_timer0_pin_out,
	output logic            o_timer0_drives_pin,
	output logic            o_timer1_true_out,
	output logic            o_timer1_pin_out,
	output logic            o_timer1_drives_pin,
	output logic            o_serial0_driver_enable,
	output logic            o_serial0_transmit
);
	////////////////////////////////////////////////////////////////////////////////
	// registered so every output changes just after an edge, like real peripherals
	always_ff @(posedge i_clk) begin
		if (!i_resetn) begin
			o_timer0_true_out <= 1'h0;
			o_timer0_pin_out <= 1'h0;
			o_timer0_drives_pin <= 1'h0;
			o_timer1_true_out <= 1'h0;
			o_timer1_pin_out <= 1'h0;
			o_timer1_drives_pin <= 1'h0;
			o_serial0_driver_enable <= 1'h0;
			o_serial0_transmit <= 1'h0;
		end else begin
			o_timer0_true_out <= i_mode[0];
			o_timer0_pin_out <= i_mode[1];
			o_timer0_drives_pin <= i_mode[2];
			o_timer1_true_out <= i_mode[3];
			o_timer1_pin_out <= i_mode[4];
			o_timer1_drives_pin <= i_mode[5];
			o_serial0_driver_enable <= i_mode[6];
			o_serial0_transmit <= i_mode[7];
		end
	end
endmodule
`default_nettype wire

/* verification/port_ab_alt_function_mux_tb.sv */
// self-checking bench for the port a / port b alternate-function mux
// assumes the peripheral side model; this module is the apb master
`timescale 1ns/10ps
`default_nettype none
module port_ab_alt_function_mux_tb;
	import port_mux_pkg::*;
	logic        clk = 1'h0;
	logic        resetn = 1'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [7:0]  pa_pad = 8'h00;
	logic [7:0]  pb_pad = 8'h00;
	logic        crystal = 1'h0;
	logic [7:0]  pmode = 8'h00;
	logic [31:0] prdata;
	logic        pready, pslverr;
	logic [7:0]  pa_out, pa_oe, pb_out, pb_oe;
	logic        t0_true, t0_pin, t0_drv, t1_true, t1_pin, t1_drv, ser_de, ser_tx;
	logic        t0_in, t1_in, cts, rxd, ext_clk, vref;
	logic [4:0]  analog;
	logic [7:0]  rm [0:7];
	int          order [8] = '{2, 3, 4, 5, 6, 7, 0, 1};
	int          mismatches = 0;
	int          samples_checked = 0;
	integer      seed = 32'h6F8A;
	logic [31:0] r;
	logic        e;
	////////////////////////////////////////////////////////////////////////////////
	always #10 clk = ~clk;
	port_ab_alt_function_mux #(.BUILD_28PIN(1'h1)) dut_u (
		.i_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_pa_pad(pa_pad), .i_pb_pad(pb_pad),
		.o_pa_out(pa_out), .o_pa_oe(pa_oe), .o_pb_out(pb_out), .o_pb_oe(pb_oe),
		.i_crystal_enable(crystal), .i_timer0_true_out(t0_true),
		.i_timer0_pin_out(t0_pin), .i_timer0_drives_pin(t0_drv),
		.i_timer1_true_out(t1_true), .i_timer1_pin_out(t1_pin),
		.i_timer1_drives_pin(t1_drv), .i_serial0_driver_enable(ser_de),
		.i_serial0_transmit(ser_tx), .o_timer0_pin_in(t0_in), .o_timer1_pin_in(t1_in),
		.o_serial0_clear_to_send(cts), .o_serial0_receive(rxd),
		.o_external_clock_input(ext_clk), .o_analog_connect(analog), .o_vref_connect(vref));
	peripheral_side_model model_u (
		.i_clk(clk), .i_resetn(resetn), .i_mode(pmode), .o_timer0_true_out(t0_true),
		.o_timer0_pin_out(t0_pin), .o_timer0_drives_pin(t0_drv),
		.o_timer1_true_out(t1_true), .o_timer1_pin_out(t1_pin),
		.o_timer1_drives_pin(t1_drv), .o_serial0_driver_enable(ser_de),
		.o_serial0_transmit(ser_tx));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic er);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// no limit here: the watchdog ends a hung handshake
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		q = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		apb(1'h1, 8'(i * 4), {24'h0, d}, r, e);
		rm[i] = d;
	endtask
	// expected pad and peripheral sides rebuilt from the stored register copy
	task automatic check_routing;
		logic [7:0] afo, afd, eoe, eout, boe;
		afo = {1'h1, pmode[5], 1'h1, 2'h0, 2'h3, pmode[2]};
		afd = {pmode[3], pmode[4], pmode[7], 2'h0, pmode[6], pmode[0], pmode[1]};
		eoe = (rm[4] & ~rm[0]) | (afo & rm[0]);
		eout = (rm[6] & ~rm[0]) | (afd & rm[0]);
		if (crystal) eoe[1:0] = 2'h0;
		boe = rm[5] & ~rm[1];
		chk({pa_oe, pb_oe, pa_out & pa_oe, pb_out & pb_oe},
			{eoe, boe, eout & eoe, rm[7] & boe});
		chk({21'h0, t0_in, t1_in, cts, rxd, ext_clk, vref, analog},
			{21'h0, rm[0][0] & ~pmode[2] & ~crystal & pa_pad[0], rm[0][6] & ~pmode[5] & pa_pad[6],
			~rm[0][3] | pa_pad[3], ~rm[0][4] | pa_pad[4], rm[1][3] & ~rm[2][3] & pb_pad[3],
			rm[1][5] & rm[2][5], rm[1][4:0] & rm[2][4:0]});
	endtask
	task automatic summarize;
		if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		for (int i = 0; i < 8; i++) rm[i] = 8'h00;
		repeat (12) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		check_routing;
		for (int i = 0; i < 9; i++) begin
			apb(1'h0, 8'(i * 4), 32'h0, r, e);
			chk(r, 32'h0);
		end
		// level register ignores writes; unmapped place refuses both ways
		apb(1'h1, OFS_PIN_LEVELS, 32'hFFFF_FFFF, r, e);
		apb(1'h0, OFS_PIN_LEVELS, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h0);
		apb(1'h1, 8'h24, 32'hFFFF_FFFF, r, e);
		chk({31'h0, e}, 32'h1);
		apb(1'h0, 8'h24, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h8000_0000);
		for (int k = 0; k < 60; k++) begin
			pa_pad <= 8'($random(seed));
			pb_pad <= 8'($random(seed));
			crystal <= 1'($random(seed));
			pmode <= 8'($random(seed));
			foreach (order[j]) wr(order[j], 8'($random(seed)));
			repeat (6) @(posedge clk);
			check_routing;
			apb(1'h0, OFS_PIN_LEVELS, 32'h0, r, e);
			chk(r, {16'h0, pb_pad, pa_pad});
			apb(1'h0, 8'((k % 8) * 4), 32'h0, r, e);
			chk(r, {24'h0, rm[k % 8]});
		end
		summarize;
	end
	// a hung handshake stops here; the run needs some 2200 cycles
	initial begin
		repeat (30000) @(posedge clk);
		mismatches++;
		summarize;
	end
endmodule
`default_nettype wire
